// File: core/pmdi_pkg.sv
package pmdi_pkg;

    // modelled time base: one sys_clk cycle stands for one tick of this rate
    localparam int unsigned TIME_BASE_HZ = 100_000_000;
    // system clock, used for absolute times such as the heartbeat pulse
    localparam int unsigned SYS_CLK_HZ = 20_000_000;
    localparam int unsigned SYS_CLK_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;

    // link clock frequencies seen by the mac
    localparam int unsigned MII100_CLK_HZ = 25_000_000;
    localparam int unsigned MII10_CLK_HZ = 2_500_000;
    localparam int unsigned RMII_REF_HZ = 50_000_000;
    localparam int unsigned SERIAL_CLK_HZ = 10_000_000;

    // half periods of each link clock, in time base ticks
    localparam int unsigned HALF_MII100 = TIME_BASE_HZ / (2 * MII100_CLK_HZ);
    localparam int unsigned HALF_MII10 = TIME_BASE_HZ / (2 * MII10_CLK_HZ);
    localparam int unsigned HALF_RMII = TIME_BASE_HZ / (2 * RMII_REF_HZ);
    localparam int unsigned HALF_SERIAL = TIME_BASE_HZ / (2 * SERIAL_CLK_HZ);
    localparam int unsigned DIV_W = 5;

    // heartbeat (sqe test) pulse length, rounded up to whole sys_clk cycles
    localparam int unsigned HB_TIME_NS = 1000;
    localparam int unsigned HB_CYCLES = (HB_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int unsigned HB_W = 6;

    // strap encoding of the interface mode
    localparam logic [1:0] STRAP_MII = 2'h0;
    localparam logic [1:0] STRAP_RMII = 2'h1;
    localparam logic [1:0] STRAP_SERIAL = 2'h2;

    // data delivered in place of a receive word flagged as errored
    localparam logic [3:0] RX_CORRUPT_NIBBLE = 4'hE;
    localparam int unsigned NIBBLE_W = 4;
    localparam int unsigned FIFO_DEPTH_DEF = 32;

    // interface modes, one-hot
    typedef enum logic [2:0] {
        PMDI_MODE_MII = 3'h1,
        PMDI_MODE_RMII = 3'h2,
        PMDI_MODE_SERIAL = 3'h4
    } pmdi_mode_e;

    // state of the top module, all but the transmit fifo
    typedef struct packed {
        logic cfg_loaded;
        pmdi_mode_e mode;
        logic speed_100;
        logic full_duplex;
        logic hb_en;
        logic [DIV_W-1:0] div_cnt;
        logic phase;
        logic tx_en_q;
        logic tx_overflow;
        logic [HB_W-1:0] hb_cnt;
        logic tx_clk;
        logic rx_clk;
        logic rx_dv;
        logic rx_er;
        logic crs;
        logic col;
        logic [3:0] rxd;
    } pmdi_state_s;

endpackage

// File: core/pmdi_data_if.sv
`timescale 1ns/1ps

// transmit fifo with a registered output stage
module pmdi_fifo import pmdi_pkg::*; #(
    parameter int unsigned WIDTH = NIBBLE_W,
    parameter int unsigned DEPTH = FIFO_DEPTH_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    // the pointer arithmetic needs a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("pmdi_fifo depth must be a power of two, at least 2");
    end
    if (WIDTH < 1) begin : g_bad_width
        $error("pmdi_fifo width must be at least 1");
    end

    // the output stage adds one word of room, so the path holds DEPTH + 1 words
    // pointer and output stage state
    typedef struct packed {
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
        logic out_valid;
        logic [WIDTH-1:0] out_data;
    } pmdi_fifo_s;

    pmdi_fifo_s st; // registered state
    pmdi_fifo_s next_st; // next state
    logic [WIDTH-1:0] mem [DEPTH]; // storage words
    logic full; // all words taken
    logic empty; // no word stored
    logic push; // word accepted this cycle
    logic pop; // word moved into the output stage

    // full when the pointers differ only in the wrap bit
    assign full = (st.wr_ptr[AW] != st.rd_ptr[AW]) && (st.wr_ptr[AW-1:0] == st.rd_ptr[AW-1:0]);
    assign empty = (st.wr_ptr == st.rd_ptr);
    assign in_ready = !full;
    assign push = in_valid && !full;
    // a word leaves the output stage only on valid and ready together
    // refill the output stage when it is empty or being taken
    assign pop = !empty && (!st.out_valid || out_ready);
    assign out_valid = st.out_valid;
    assign out_data = st.out_data;

    // next pointers and output stage
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wr_ptr = st.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_st.rd_ptr = st.rd_ptr + 1'b1;
            next_st.out_valid = 1'b1;
            next_st.out_data = mem[st.rd_ptr[AW-1:0]];
        end else if (out_ready) begin
            next_st.out_valid = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // storage has no reset; it is only read behind the pointers
    always_ff @(posedge clk) begin
        if (push) begin
            mem[st.wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule

module pmdi_data_if import pmdi_pkg::*; #(
    parameter int unsigned FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // configuration straps, caught once after reset
    input wire logic [1:0] strap_mode,
    input wire logic strap_speed_100,
    input wire logic strap_full_duplex,
    input wire logic strap_heartbeat_en,
    // mac transmit side
    output logic tx_clk,
    input wire logic tx_en,
    input wire logic [3:0] txd,
    // mac receive side
    output logic rx_clk,
    output logic rx_dv,
    output logic rx_er,
    output logic [3:0] rxd,
    output logic crs,
    output logic col,
    // line side transmit stream
    output logic line_tx_valid,
    input wire logic line_tx_ready,
    output logic [3:0] line_tx_data,
    // line side receive stream
    input wire logic line_rx_valid,
    input wire logic [3:0] line_rx_data,
    input wire logic line_rx_error,
    input wire logic line_rx_carrier,
    // status
    output logic [2:0] active_mode,
    output logic tx_overflow
);
    // the divider and heartbeat counters must hold their largest counts
    if (HALF_MII10 >= (1 << DIV_W) || HB_CYCLES >= (1 << HB_W)) begin : g_bad_counts
        $error("pmdi_data_if counter widths too small");
    end
    // the fifo checks its own depth for a power of two as well
    if (FIFO_DEPTH < 2) begin : g_bad_fifo
        $error("pmdi_data_if fifo depth must be at least 2");
    end

    // one flat state struct keeps the reset value and the next-state copy in step;
    // the fifo storage stays outside it because it needs no reset
    pmdi_state_s st; // registered state
    pmdi_state_s next_st; // next state
    logic [DIV_W-1:0] half_cnt; // half period of the active link clock
    logic toggle; // link clock flips this cycle
    logic rise; // link clock rising: mac inputs are sampled
    logic fall; // link clock falling: mac outputs are launched
    logic fifo_in_valid; // transmit word offered to the fifo
    logic fifo_in_ready; // fifo has room
    logic fifo_out_valid; // fifo output stage valid
    logic [3:0] fifo_out_data; // fifo output word
    logic [3:0] tx_word; // transmit word masked to the mode width
    logic ten_mb; // running at 10 mb/s
    logic half_duplex; // collision and heartbeat allowed
    logic [3:0] rx_word; // receive word masked to the mode width

    // the counts are in time base ticks, one per sys_clk cycle
    // half period select per mode and speed
    always_comb begin
        case (st.mode)
            PMDI_MODE_RMII: half_cnt = DIV_W'(HALF_RMII);
            PMDI_MODE_SERIAL: half_cnt = DIV_W'(HALF_SERIAL);
            PMDI_MODE_MII: half_cnt = st.speed_100 ? DIV_W'(HALF_MII100) : DIV_W'(HALF_MII10);
            default: half_cnt = DIV_W'(HALF_MII100);
        endcase
    end

    // clock phase events, only once the configuration is loaded
    // rise and fall last one sys_clk cycle each; the pins follow one edge later
    assign toggle = st.cfg_loaded && (st.div_cnt == half_cnt - 1'b1);
    assign rise = toggle && !st.phase;
    assign fall = toggle && st.phase;
    // serial mode is 10 mb/s only and always shares the medium
    assign ten_mb = (st.mode == PMDI_MODE_SERIAL) || !st.speed_100;
    assign half_duplex = (st.mode == PMDI_MODE_SERIAL) || !st.full_duplex;

    // bits above the mode width read as zero so the line side need not mask them
    // transmit word kept to the bits the mode defines; the mac keeps enable framing the data
    always_comb begin
        case (st.mode)
            PMDI_MODE_RMII: tx_word = {2'h0, txd[1:0]};
            PMDI_MODE_SERIAL: tx_word = {3'h0, txd[0]};
            PMDI_MODE_MII: tx_word = txd;
            default: tx_word = txd;
        endcase
    end

    // a word is taken on each rising link clock edge while enable is high
    assign fifo_in_valid = rise && tx_en;

    // serial uses bit 0 only; the other bits stay low as the mode requires
    // receive word kept to the bits the mode defines
    always_comb begin
        case (st.mode)
            PMDI_MODE_RMII: rx_word = {2'h0, line_rx_data[1:0]};
            PMDI_MODE_SERIAL: rx_word = {3'h0, line_rx_data[0]};
            PMDI_MODE_MII: rx_word = line_rx_data;
            default: rx_word = line_rx_data;
        endcase
    end

    // main state update
    always_comb begin
        next_st = st;
        // straps are caught on the first edge after reset release, never under reset
        // a new reset is the only way to change the mode
        if (!st.cfg_loaded) begin
            next_st.cfg_loaded = 1'b1;
            case (strap_mode)
                STRAP_RMII: next_st.mode = PMDI_MODE_RMII;
                STRAP_SERIAL: next_st.mode = PMDI_MODE_SERIAL;
                default: next_st.mode = PMDI_MODE_MII;
            endcase
            next_st.speed_100 = strap_speed_100;
            next_st.full_duplex = strap_full_duplex;
            next_st.hb_en = strap_heartbeat_en;
        end else begin
            // link clock divider
            if (toggle) begin
                next_st.div_cnt = '0;
                next_st.phase = !st.phase;
            end else begin
                next_st.div_cnt = st.div_cnt + 1'b1;
            end
        end

        // clock pins follow the phase except in rmii, where they rest low
        next_st.tx_clk = (st.mode != PMDI_MODE_RMII) && next_st.phase;
        next_st.rx_clk = (st.mode != PMDI_MODE_RMII) && next_st.phase;

        // rmii keeps the divider running so that rise still paces the dibit sampling
        // transmit activity and overflow, tracked at the sampling edge
        if (rise) begin
            next_st.tx_en_q = tx_en;
            // heartbeat after each transmission ends, 10 mb half duplex only
            if (st.tx_en_q && !tx_en && st.hb_en && ten_mb && half_duplex) begin
                next_st.hb_cnt = HB_W'(HB_CYCLES);
            end
            // overflow stands for the rest of the frame; the first rise with enable low clears it
            if (tx_en && !fifo_in_ready) begin
                next_st.tx_overflow = 1'b1;
            end else if (!tx_en) begin
                next_st.tx_overflow = 1'b0;
            end
        end
        // count the heartbeat down, except in the cycle that reloads it
        if (st.hb_cnt != '0 && next_st.hb_cnt == st.hb_cnt) begin
            next_st.hb_cnt = st.hb_cnt - 1'b1;
        end

        // limitation: the receive outputs sample the line inputs only at fall, so a word shorter than
        // one link period can be missed; the line side must hold each word that long
        // receive outputs launched on the falling edge so the mac samples them stable
        if (fall) begin
            case (st.mode)
                PMDI_MODE_MII: begin
                    next_st.rx_dv = line_rx_valid;
                    next_st.rx_er = line_rx_valid && line_rx_error && st.speed_100;
                    next_st.crs = line_rx_carrier;
                    if (!line_rx_valid) begin
                        next_st.rxd = 4'h0;
                    end else if (line_rx_error) begin
                        next_st.rxd = RX_CORRUPT_NIBBLE;
                    end else begin
                        next_st.rxd = rx_word;
                    end
                end
                PMDI_MODE_RMII: begin
                    next_st.rx_dv = line_rx_valid;
                    next_st.rx_er = line_rx_valid && line_rx_error && st.speed_100;
                    next_st.crs = line_rx_carrier || line_rx_valid;
                    if (!line_rx_valid) begin
                        next_st.rxd = 4'h0;
                    end else if (line_rx_error) begin
                        next_st.rxd = RX_CORRUPT_NIBBLE & 4'h3;
                    end else begin
                        next_st.rxd = rx_word;
                    end
                end
                PMDI_MODE_SERIAL: begin
                    next_st.rx_dv = 1'b0;
                    next_st.rx_er = 1'b0;
                    next_st.crs = line_rx_carrier;
                    // one bit, framed by carrier; errored bits are corrupted as well
                    if (!line_rx_carrier) begin
                        next_st.rxd = 4'h0;
                    end else if (line_rx_error) begin
                        next_st.rxd = {3'h0, ~line_rx_data[0]};
                    end else begin
                        next_st.rxd = rx_word;
                    end
                end
                default: begin
                    next_st.rx_dv = 1'b0;
                    next_st.rx_er = 1'b0;
                    next_st.crs = 1'b0;
                    next_st.rxd = 4'h0;
                end
            endcase
        end

        // collision: simultaneous activity in half duplex, plus the heartbeat pulse;
        // rmii has no collision pin, the mac works it out itself
        // col is worked out every cycle rather than at fall, so a collision
        // reaches the mac without waiting for the slow 10 mb/s clock
        if (st.mode == PMDI_MODE_RMII || !half_duplex) begin
            next_st.col = 1'b0;
        end else begin
            next_st.col = (st.tx_en_q && line_rx_carrier) || (next_st.hb_cnt != '0);
        end
    end

    // state register
    // reset leaves mii selected so the pins read as the default mode
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st <= '{mode: PMDI_MODE_MII, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // transmit words wait here until the line side takes them; a stalled
    // line side fills it, and a full fifo drops words and flags overflow;
    // the fifo runs on sys_clk too, so no clock crossing is needed on this path
    pmdi_fifo #(
        .WIDTH(NIBBLE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk(sys_clk),
        .reset(reset),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(tx_word),
        .out_valid(fifo_out_valid),
        .out_ready(line_tx_ready),
        .out_data(fifo_out_data)
    );

    // outputs straight from flip-flops
    assign tx_clk = st.tx_clk;
    assign rx_clk = st.rx_clk;
    assign rx_dv = st.rx_dv;
    assign rx_er = st.rx_er;
    assign rxd = st.rxd;
    assign crs = st.crs;
    assign col = st.col;
    // the line stream comes from the fifo output stage, itself a flip-flop
    assign line_tx_valid = fifo_out_valid;
    assign line_tx_data = fifo_out_data;
    assign active_mode = st.mode;
    assign tx_overflow = st.tx_overflow;
endmodule

// File: verification/pmdi_data_if_chk.sv
`timescale 1ns/1ps

// watches the mac and line ports of the data interface
module pmdi_data_if_chk import pmdi_pkg::*; #(
    parameter int unsigned FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // straps
    input wire logic strap_speed_100,
    input wire logic strap_full_duplex,
    // mac side
    input wire logic tx_clk,
    input wire logic tx_en,
    input wire logic rx_clk,
    input wire logic rx_dv,
    input wire logic rx_er,
    input wire logic [3:0] rxd,
    input wire logic crs,
    input wire logic col,
    // line side and status
    input wire logic line_tx_valid,
    input wire logic line_tx_ready,
    input wire logic [3:0] line_tx_data,
    input wire logic line_rx_carrier,
    input wire logic [2:0] active_mode
);
    // length of the current collision run, to time the heartbeat
    logic [7:0] col_run;

    // count consecutive cycles with col high
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            col_run <= 8'h00;
        end else begin
            col_run <= col ? col_run + 8'h01 : 8'h00;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_mode_onehot: assert property ($onehot(active_mode))
        else $error("mode not one-hot");
    // the capture edge itself is exempt, hence depth two
    a_mode_fixed: assert property (!$past(reset, 2) |-> $stable(active_mode))
        else $error("mode changed after capture");
    a_rmii_clk_idle: assert property (active_mode == PMDI_MODE_RMII |-> !tx_clk && !rx_clk)
        else $error("link clock toggles in rmii");
    a_rx_clk_match: assert property (rx_clk == tx_clk)
        else $error("receive clock differs");
    a_col_overlap: assert property ((active_mode == PMDI_MODE_MII && strap_speed_100 && !strap_full_duplex
        && tx_en && line_rx_carrier)[*8] |-> col)
        else $error("collision missed");
    a_fdx_no_col: assert property (active_mode == PMDI_MODE_MII && strap_full_duplex |-> !col)
        else $error("collision in full duplex");
    a_rmii_no_col: assert property (active_mode == PMDI_MODE_RMII |-> !col)
        else $error("collision in rmii");
    a_serial_unused: assert property (active_mode == PMDI_MODE_SERIAL |-> !rx_dv && !rx_er && rxd[3:1] == 3'h0)
        else $error("unused pins active in serial");
    a_serial_framed: assert property (active_mode == PMDI_MODE_SERIAL && !crs |-> rxd == 4'h0)
        else $error("serial data without carrier");
    a_mii_gate: assert property (active_mode == PMDI_MODE_MII && !rx_dv |-> rxd == 4'h0 && !rx_er)
        else $error("nibble without valid");
    a_er_needs_dv: assert property (rx_er |-> rx_dv && strap_speed_100)
        else $error("error outside valid data");
    a_line_hold: assert property (line_tx_valid && !line_tx_ready |=> line_tx_valid && $stable(line_tx_data))
        else $error("line word dropped while stalled");
    a_hb_length: assert property ($fell(col) && !strap_speed_100 && !strap_full_duplex
        && !$past(line_rx_carrier, 2) |-> col_run == HB_CYCLES)
        else $error("heartbeat length wrong");
endmodule

// File: verification/pmdi_mac_model.sv
`timescale 1ns/1ps

// mac transmitter: launches one word per link clock rise
module pmdi_mac_model (
    // clocks
    input wire logic sys_clk,
    input wire logic tx_clk,
    // command
    input wire logic start,
    input wire logic [3:0] base,
    input wire logic [5:0] len,
    input wire logic rmii,
    output logic busy,
    // mac transmit pins
    output logic tx_en,
    output logic [3:0] txd
);
    logic prev; // link clock one sample back
    logic [5:0] left; // words still to launch
    // rmii has no link clock pin: a word held two cycles meets exactly one reference rise
    logic pace;

    initial begin
        busy = 1'b0;
        tx_en = 1'b0;
        txd = 4'h0;
        prev = 1'b0;
        pace = 1'b0;
        left = 6'h00;
    end

    // launch just after each link clock rise and hold a full period
    always @(negedge sys_clk) begin
        if (start && !busy) begin
            busy <= 1'b1;
            left <= len;
            txd <= base;
        end else if (busy && (rmii ? pace : (tx_clk && !prev))) begin
            if (left != 6'h00) begin
                tx_en <= 1'b1;
                txd <= tx_en ? txd + 4'h1 : txd;
                left <= left - 6'h01;
            end else begin
                tx_en <= 1'b0;
                busy <= 1'b0;
            end
        end else if (!busy) begin
            txd <= ~txd; // idle data is junk, never a held value
        end
        prev <= tx_clk;
        pace <= !pace;
    end
endmodule

// File: verification/pmdi_data_if_test.sv
`timescale 1ns/1ps

module pmdi_data_if_test import pmdi_pkg::*;;
    localparam int unsigned DEPTH = 32;
    logic sys_clk, reset, start, busy, tx_en, tx_clk, rx_clk, rx_dv, rx_er, crs, col;
    logic strap_speed_100, strap_full_duplex, strap_heartbeat_en, tx_overflow, ovf_seen;
    logic line_tx_valid, line_tx_ready, line_rx_valid, line_rx_error, line_rx_carrier;
    logic [1:0] strap_mode;
    logic [3:0] txd, rxd, base, line_tx_data, line_rx_data;
    logic [5:0] len;
    logic [2:0] active_mode;
    logic [3:0] got[$]; // words seen on the line side
    int num_errors, compares, cyc, col_cnt;

    pmdi_data_if #(.FIFO_DEPTH(DEPTH)) dut (.sys_clk(sys_clk), .reset(reset), .strap_mode(strap_mode),
        .strap_speed_100(strap_speed_100), .strap_full_duplex(strap_full_duplex),
        .strap_heartbeat_en(strap_heartbeat_en), .tx_clk(tx_clk), .tx_en(tx_en), .txd(txd),
        .rx_clk(rx_clk), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd), .crs(crs), .col(col),
        .line_tx_valid(line_tx_valid), .line_tx_ready(line_tx_ready), .line_tx_data(line_tx_data),
        .line_rx_valid(line_rx_valid), .line_rx_data(line_rx_data), .line_rx_error(line_rx_error),
        .line_rx_carrier(line_rx_carrier), .active_mode(active_mode), .tx_overflow(tx_overflow));

    pmdi_mac_model mac (.sys_clk(sys_clk), .tx_clk(tx_clk), .start(start), .base(base), .len(len),
        .rmii(strap_mode == STRAP_RMII), .busy(busy), .tx_en(tx_en), .txd(txd));

    // 50 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // line sink, collision and overflow monitor, hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (col !== 1'b0) col_cnt++;
        if (tx_overflow !== 1'b0) ovf_seen = 1'b1;
        if (line_tx_ready && line_tx_valid !== 1'b0) got.push_back(line_tx_data);
        if (cyc == 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    task check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task wrap_up();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // straps are held steady from before reset until the next reset
    task restart(input logic [1:0] m, input logic spd, input logic fdx, input logic hb);
        @(negedge sys_clk);
        {strap_mode, strap_speed_100, strap_full_duplex, strap_heartbeat_en} = {m, spd, fdx, hb};
        reset = 1'b1;
        repeat (4) @(negedge sys_clk);
        reset = 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask

    // cycles from one link clock rise to the next
    task period(input int exp);
        int n;
        n = 0;
        while (tx_clk !== 1'b1 && n < 99) begin
            @(negedge sys_clk);
            n++;
        end
        n = 0;
        while (tx_clk === 1'b1 && n < 99) begin
            @(negedge sys_clk);
            n++;
        end
        while (tx_clk !== 1'b1 && n < 99) begin
            @(negedge sys_clk);
            n++;
        end
        check(8'(n), 8'(exp));
    endtask

    // one frame from the mac; a stalled line side fills the fifo
    task send(input logic [3:0] b, input logic [5:0] l, input logic stall, input logic [3:0] mask, input int n);
        got.delete();
        col_cnt = 0;
        ovf_seen = 1'b0;
        line_tx_ready = !stall;
        base = b;
        len = l;
        start <= 1'b1;
        @(negedge sys_clk);
        start <= 1'b0;
        @(negedge sys_clk);
        for (int i = 0; i < 400 && busy; i++) @(negedge sys_clk);
        repeat (30) @(negedge sys_clk);
        line_tx_ready = 1'b1;
        repeat (60) @(negedge sys_clk);
        check(8'(got.size()), 8'(n));
        for (int i = 0; i < got.size(); i++) check(8'(got[i]), 8'((b + 4'(i)) & mask));
        check(8'(ovf_seen), 8'(stall));
    endtask

    // hold line receive inputs, then compare {dv, er, crs, rxd}
    task rx_chk(input logic [6:0] in, input int n, input logic [6:0] exp);
        {line_rx_valid, line_rx_error, line_rx_carrier, line_rx_data} = in;
        repeat (n) @(negedge sys_clk);
        check(8'({rx_dv, rx_er, crs, rxd}), 8'(exp));
    endtask

    initial begin
        {start, base, len, line_tx_ready, line_rx_valid, line_rx_error, line_rx_carrier} = '0;
        {line_rx_data, num_errors, compares, cyc, col_cnt, ovf_seen} = '0;
        {strap_mode, strap_speed_100, strap_full_duplex, strap_heartbeat_en} = '0;
        reset = 1'b1;
        // mii 100: clock, frame, collision, overflow, receive
        restart(2'h0, 1'b1, 1'b0, 1'b0);
        check(8'(active_mode), 8'h01);
        period(4);
        send(4'h3, 6'h06, 1'b0, 4'hF, 6);
        check(8'(col_cnt), 8'h00);
        line_rx_carrier = 1'b1;
        send(4'h1, 6'h04, 1'b0, 4'hF, 4);
        check(8'(col_cnt != 0), 8'h01);
        line_rx_carrier = 1'b0;
        send(4'h0, 6'h28, 1'b1, 4'hF, DEPTH + 1);
        rx_chk(7'h55, 8, 7'h55);
        rx_chk(7'h75, 8, 7'h7E);
        rx_chk(7'h15, 8, 7'h10);
        rx_chk(7'h00, 8, 7'h00);
        // mii 10 half duplex heartbeat, then full duplex
        restart(2'h0, 1'b0, 1'b0, 1'b1);
        period(40);
        send(4'h9, 6'h02, 1'b0, 4'hF, 2);
        check(8'(col_cnt), 8'(HB_CYCLES));
        restart(2'h0, 1'b0, 1'b1, 1'b1);
        line_rx_carrier = 1'b1;
        send(4'h5, 6'h02, 1'b0, 4'hF, 2);
        check(8'(col_cnt), 8'h00);
        line_rx_carrier = 1'b0;
        // rmii: no link clocks, combined carrier and valid
        restart(2'h1, 1'b1, 1'b0, 1'b0);
        check(8'(active_mode), 8'h02);
        repeat (10) @(negedge sys_clk);
        check(8'({tx_clk, rx_clk}), 8'h00);
        rx_chk(7'h1B, 4, 7'h10);
        rx_chk(7'h4B, 4, 7'h53);
        rx_chk(7'h7B, 4, 7'h72);
        check(8'(col), 8'h00);
        send(4'hD, 6'h05, 1'b0, 4'h3, 5);
        check(8'(col_cnt), 8'h00);
        rx_chk(7'h00, 4, 7'h00);
        // serial: 10 mhz clock, one data bit framed by carrier
        restart(2'h2, 1'b0, 1'b0, 1'b1);
        check(8'(active_mode), 8'h04);
        period(10);
        send(4'h6, 6'h05, 1'b0, 4'h1, 5);
        check(8'(col_cnt), 8'(HB_CYCLES));
        rx_chk(7'h51, 12, 7'h11);
        rx_chk(7'h71, 12, 7'h10);
        rx_chk(7'h41, 12, 7'h00);
        wrap_up();
    end
endmodule

bind pmdi_data_if pmdi_data_if_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.sys_clk(sys_clk), .reset(reset),
    .strap_speed_100(strap_speed_100), .strap_full_duplex(strap_full_duplex), .tx_clk(tx_clk),
    .tx_en(tx_en), .rx_clk(rx_clk), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd), .crs(crs), .col(col),
    .line_tx_valid(line_tx_valid), .line_tx_ready(line_tx_ready), .line_tx_data(line_tx_data),
    .line_rx_carrier(line_rx_carrier), .active_mode(active_mode));
